/* File: hdl/pdsl_divider_load.sv */
// Serial divider programming: shift register on the shift clock, latches and APB view
`timescale 1ns/1ps
`default_nettype none

module pdsl_divider_load
  import pdsl_pkg::*;
(
  // System clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Serial programming link
  input  wire logic                 shift_clk,
  input  wire logic                 serial_data,
  input  wire logic                 load_strobe,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Divider ratios
  output logic [SWALLOW_W-1:0]      swallow_count,
  output logic [MAIN_W-1:0]         main_count,
  output logic [REF_W-1:0]          ref_count
);

  // Matches a select code taken from the shift register
  function automatic logic sel_match(input logic [SR_W-1:0] sr, input logic [1:0] code);
    sel_match = ({sr[SEL_LOW_POS], sr[SEL_HIGH_POS]} == code);
  endfunction

  pdsl_apb_req_t   apb;
  logic [SR_W-1:0] shift_ff;
  logic            strobe_meta_ff;
  logic            strobe_sync_ff;
  logic            load_en_ff;
  logic            main_ld_ff;
  logic            ref_ld_ff;
  pdsl_main_t      main_ff;
  logic [REF_W-1:0] ref_ff;
  logic [31:0]     prdata_ff;
  logic            pslverr_ff;

  // Shift clock domain: no reset, contents undefined until a full word has been shifted
  always_ff @(posedge shift_clk)
  begin
    shift_ff <= {shift_ff[SR_W-2:0], serial_data};
  end

  // Strobe crosses to ref_clk through two flops; shift data is static while it is high
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      strobe_meta_ff <= 1'b0;
      strobe_sync_ff <= 1'b0;
    end
    else
    begin
      strobe_meta_ff <= load_strobe;
      strobe_sync_ff <= strobe_meta_ff;
    end
  end

  // Latch enables: strobe AND load enable AND decoded select; the word is quasi-static while the strobe is high
  wire load_main = strobe_sync_ff & load_en_ff & sel_match(shift_ff, SEL_MAIN);
  wire load_ref  = strobe_sync_ff & load_en_ff & sel_match(shift_ff, SEL_REF);
  wire [SWALLOW_W-1:0] word_swallow = shift_ff[MAIN_LSB-1:SWALLOW_LSB];
  wire [MAIN_W-1:0]    word_main    = shift_ff[SR_W-1:MAIN_LSB];
  wire [REF_W-1:0]     word_ref     = shift_ff[REF_WORD_W-1:REF_LSB];

  // APB decode
  assign apb = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  wire apb_setup  = apb.psel & ~apb.penable;
  wire apb_wr     = apb.psel & apb.penable & apb.pwrite;
  wire hit_ctrl   = (apb.paddr == ADDR_CTRL);
  wire hit_status = (apb.paddr == ADDR_STATUS);
  wire hit_main   = (apb.paddr == ADDR_MAIN);
  wire hit_ref    = (apb.paddr == ADDR_REF);
  wire hit_any    = hit_ctrl | hit_status | hit_main | hit_ref;
  wire clr_main   = apb_wr & hit_status & apb.pwdata[STAT_MAIN_LD];
  wire clr_ref    = apb_wr & hit_status & apb.pwdata[STAT_REF_LD];

  // Read mux, registered in the setup cycle so data comes from flops
  logic [31:0] nxt_prdata;
  always_comb
  begin
    nxt_prdata = ZERO32;
    if (hit_ctrl)
      nxt_prdata[CTRL_LOAD_EN] = load_en_ff;
    if (hit_status)
    begin
      nxt_prdata[STAT_MAIN_LD] = main_ld_ff;
      nxt_prdata[STAT_REF_LD]  = ref_ld_ff;
      nxt_prdata[STAT_STROBE]  = strobe_sync_ff;
    end
    if (hit_main)
      nxt_prdata[MAIN_REG_NLSB+MAIN_W-1:0] = main_ff;
    if (hit_ref)
      nxt_prdata[REF_W-1:0] = ref_ff;
  end

  // APB response and control register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prdata_ff  <= ZERO32;
      pslverr_ff <= 1'b0;
      load_en_ff <= LOAD_EN_RST;
    end
    else
    begin
      if (apb_setup)
      begin
        prdata_ff  <= apb.pwrite ? ZERO32 : nxt_prdata;
        pslverr_ff <= ~hit_any;
      end
      if (apb_wr & hit_ctrl)
        load_en_ff <= apb.pwdata[CTRL_LOAD_EN];
    end
  end

  // Loaded flags: a load in the same cycle as a clear wins
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      main_ld_ff <= 1'b0;
      ref_ld_ff  <= 1'b0;
    end
    else
    begin
      main_ld_ff <= load_main | (main_ld_ff & ~clr_main);
      ref_ld_ff  <= load_ref  | (ref_ld_ff  & ~clr_ref);
    end
  end

  // Divider latches, each touched only by its own enable
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      main_ff <= '0;
      ref_ff  <= '0;
    end
    else
    begin
      if (load_main)
        main_ff <= '{main_count: word_main, swallow_count: word_swallow};
      if (load_ref)
        ref_ff <= word_ref;
    end
  end

  assign pready        = 1'b1;
  assign prdata        = prdata_ff;
  assign pslverr       = pslverr_ff & apb.psel & apb.penable;
  assign swallow_count = main_ff.swallow_count;
  assign main_count    = main_ff.main_count;
  assign ref_count     = ref_ff;

endmodule

`default_nettype wire

/* File: hdl/pdsl_pkg.sv */
// Package of constants and types for the divider serial-load block
package pdsl_pkg;

  // Word layout inside the serial shift register (newest bit at index 0)
  localparam int SR_W        = 20;
  localparam int REF_WORD_W  = 16;
  localparam int SWALLOW_W   = 6;
  localparam int MAIN_W      = 12;
  localparam int REF_W       = 14;
  localparam int SEL_HIGH_POS = 0;
  localparam int SEL_LOW_POS  = 1;
  localparam int SWALLOW_LSB = 2;
  localparam int MAIN_LSB    = SWALLOW_LSB + SWALLOW_W;
  localparam int REF_LSB     = 2;

  // Select codes {select_bit_low, select_bit_high}
  localparam logic [1:0] SEL_MAIN = 2'h0;
  localparam logic [1:0] SEL_REF  = 2'h1;

  // APB register byte addresses
  localparam int         ADDR_W      = 12;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_MAIN   = 12'h008;
  localparam logic [11:0] ADDR_REF    = 12'h00c;

  // Field positions
  localparam int CTRL_LOAD_EN   = 0;
  localparam int STAT_MAIN_LD   = 0;
  localparam int STAT_REF_LD    = 1;
  localparam int STAT_STROBE    = 2;
  localparam int MAIN_REG_NLSB  = 6;

  // Reset values
  localparam logic [31:0] ZERO32     = 32'h0000_0000;
  localparam logic        LOAD_EN_RST = 1'b1;

  // Latched main divider ratio
  typedef struct packed {
    logic [MAIN_W-1:0]    main_count;
    logic [SWALLOW_W-1:0] swallow_count;
  } pdsl_main_t;

  // APB request bundle
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } pdsl_apb_req_t;

endpackage

/* File: dv/pdsl_divider_load_monitor.sv */
// Port checker for the divider load block
`timescale 1ns/1ps
`default_nettype none
module pdsl_monitor
  import pdsl_pkg::*;
(
  // Clock, reset, strobe
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic                 load_strobe,
  // APB
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [ADDR_W-1:0]    paddr,
  input wire logic [31:0]          prdata,
  input wire logic                 pslverr,
  // Ratios
  input wire logic [SWALLOW_W-1:0] swallow_count,
  input wire logic [MAIN_W-1:0]    main_count,
  input wire logic [REF_W-1:0]     ref_count
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Reads are only judged while the strobe rests, as latches may reload
  wire rd = psel && penable && !pwrite && !load_strobe;
  chk_ratio_hold: assert property (!load_strobe [*6] |-> $stable({main_count, ref_count}))
    else $error("ratio moved without strobe");
  chk_strobe_steady: assert property (load_strobe [*5] |-> $stable({main_count, swallow_count, ref_count}))
    else $error("ratio moved under a held strobe");
  chk_main_view: assert property (rd && paddr == ADDR_MAIN |-> prdata[17:0] == {main_count, swallow_count})
    else $error("main view wrong");
  chk_ref_view: assert property (rd && paddr == ADDR_REF |-> prdata == 32'(ref_count))
    else $error("ref view wrong");
  chk_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  chk_err_unmapped: assert property (psel && penable && paddr > ADDR_REF |-> pslverr)
    else $error("no error on unmapped");
  chk_err_mapped: assert property (psel && penable && paddr == ADDR_CTRL |-> !pslverr)
    else $error("error on mapped");
  chk_reset_clear: assert property ($past(rst) |-> main_count == 0 && ref_count == 0)
    else $error("ratios not cleared");
endmodule
bind pdsl_divider_load pdsl_monitor u_pdsl_monitor (.ref_clk, .rst, .load_strobe, .psel, .penable,
  .pwrite, .paddr, .prdata, .pslverr, .swallow_count, .main_count, .ref_count);
`default_nettype wire

/* File: dv/pdsl_host_model.sv */
// Host controller model on the serial programming link
`timescale 1ns/1ps
`default_nettype none
module pdsl_host_model (
  // Serial link
  output logic shift_clk,
  output logic serial_data,
  output logic load_strobe
);
  initial {shift_clk, serial_data, load_strobe} = 3'h0;
  // First bit first; the clock only runs inside a frame
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--)
    begin
      serial_data = w[i];
      #8 shift_clk = 1'b1;
      #15 shift_clk = 1'b0;
      #7;
    end
    // Released line shows the inverse so a stale bit cannot pass
    serial_data = ~serial_data;
    #20 load_strobe = 1'b1;
    #150 load_strobe = 1'b0;
    #150;
  endtask
endmodule
`default_nettype wire

/* File: dv/pdsl_divider_load_tb.sv */
// Self-checking bench for the divider serial-load block
`timescale 1ns/1ps
`default_nettype none
module pdsl_divider_load_tb
  import pdsl_pkg::*;
  ;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, g, rng = 32'h7434_129f;
  logic pready, pslverr, er, en, shift_clk, serial_data, load_strobe;
  logic [SWALLOW_W-1:0] swallow_count;
  logic [MAIN_W-1:0] main_count;
  logic [REF_W-1:0] ref_count;
  logic [1:0] sel;
  logic [23:0] w;
  int errors = 0, n_compared = 0, e_main = 0, e_ref = 0, e_st = 0, sw, nm, rf;
  always #12.5 ref_clk = ~ref_clk;
  pdsl_divider_load u_pdsl_divider_load (.ref_clk, .rst, .shift_clk, .serial_data, .load_strobe,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .swallow_count,
    .main_count, .ref_count);
  pdsl_host_model u_pdsl_host_model (.shift_clk, .serial_data, .load_strobe);
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic give_verdict();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, entered just after a rising edge; idle edge after it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50)
    begin
      errors++;
      give_verdict();
    end
    @(posedge ref_clk);
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    cmp(rd, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0000_0000);
    cmp({rd[30:0], er}, 32'h0000_0001);
    // Reference then main first, then every code, with surplus leading bits
    for (int i = 0; i < 12; i++)
    begin
      sel = (i < 2) ? 2'(1 - i) : 2'(rnd());
      en = (i != 5);
      g = rnd();
      sw = (i == 2) ? 63 : rnd() % 64;
      nm = (i == 2) ? 4095 : 5 + rnd() % 4091;
      rf = (i == 3) ? 16383 : 5 + rnd() % 16379;
      w = sel[0] ? {g[7:0], 14'(rf), sel} : {g[3:0], 12'(nm), 6'(sw), sel};
      apb(1'b1, ADDR_CTRL, {31'h0, en});
      u_pdsl_host_model.send(w);
      if (en && sel == SEL_MAIN)
        e_main = nm * 64 + sw;
      if (en && sel == SEL_REF)
        e_ref = rf;
      e_st = e_st | int'(en && sel == SEL_MAIN) | (int'(en && sel == SEL_REF) << 1);
      @(posedge ref_clk);
      apb(1'b0, ADDR_MAIN, 32'h0000_0000);
      cmp(rd, e_main);
      cmp({14'h0, main_count, swallow_count}, e_main);
      apb(1'b0, ADDR_REF, 32'h0000_0000);
      cmp(rd, e_ref);
      cmp(32'(ref_count), e_ref);
      // Loaded flags set only by an enabled load, cleared by writing ones
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      cmp(rd, e_st);
      apb(1'b1, ADDR_STATUS, 32'h0000_0003);
      e_st = 0;
    end
    give_verdict();
  end
endmodule
`default_nettype wire
